/* File: core/hvd_pkg.sv */
/*
  Shared constants of the high-voltage DAC serial control pair: frame layout,
  select codes, control bit positions, reset values and serial timing.
  Assumes a 25 MHz system clock on both ends and a slow serial clock.
*/
// Function
// (R1) Clear falling edge zeroes input and output registers
// (R2) Load falling edge copies input to output
// (R3) Load low at execution: update output directly
// (R4) Over-temperature powers analog down, logic keeps running
// (R5) Shutdown sets thermal flag and drives alarm low
// (R6) Shutdown latched until control write clears flag
// (R7) Output register never written or read serially
// (R8) Sixteen bits, MSB first: rw, select, data
// (R9) Write: rw zero, 001 input, 111 control
// (R10) Frame select fall starts; bits sampled rising
// (R11) Sixteenth falling clock edge executes the command
// (R12) Frame select high minimum time between frames
// (R13) Serial clock may stop between frames
// (R14) Read: rw one, twelve data bits shifted out
// (R15) Data output driven from fifth rising edge
// (R16) Master keeps read clock at most 9 MHz
// (R17) Select bits all ones means control access
// (R18) Master sends another write after control write; hvd_host does not, the testbench does so only in its control test
// (R19) Reset: control 0x40, data registers zero
// (R20) Control bit two powers the channel up
// (R21) Control bit six floats output, else grounds
// (R22) Control bit zero reports thermal shutdown
// (R23) Select 000 or reserved codes change nothing
// (R24) Frame aborted early by select rise discarded
package hvd_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Frame layout
  localparam int FRAME_BITS = 16;          // Bits per frame
  localparam int DATA_BITS = 12;           // Payload bits
  localparam int RW_POS = 15;              // Read/write bit
  localparam int SEL_MSB = 14;             // Register select field
  localparam int SEL_LSB = 12;
  localparam logic [4:0] LAST_EDGE = 5'h10;      // Sixteenth clock edge
  localparam logic [4:0] READ_DRIVE_CNT = 5'h04; // Edges seen before fifth
  localparam logic [4:0] FIRST_SAMPLE_BIT = 5'h06; // Host: first read sample

  // Register select codes
  localparam logic [2:0] SEL_NOP = 3'h0;
  localparam logic [2:0] SEL_INPUT = 3'h1;
  localparam logic [2:0] SEL_CTRL = 3'h7;

  // Control bit positions within the payload
  localparam int THERMAL_FLAG_POS = 0;
  localparam int POWER_UP_POS = 2;
  localparam int FLOAT_SEL_POS = 6;

  // Values after reset
  localparam logic [11:0] CTRL_RESET = 12'h040;
  localparam logic [11:0] DATA_RESET = 12'h000;
  // Synchroniser idle: sclk, frame_n, sdi, clear_n, load_n, hot
  localparam logic [5:0] SYNC_IDLE = 6'b01_0110;

  ////////////////////////////////////////////////////////////////////////////
  // Timing
  localparam int CLK_PERIOD_NS = 40;       // 25 MHz system clock
  localparam int SCLK_HALF_NS = 160;       // Host serial clock half period
  localparam int SCLK_HALF_CYC = (SCLK_HALF_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int FRAME_GAP_MIN_NS = 20;    // Least frame select high time
  localparam int FRAME_GAP_CYC = (FRAME_GAP_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int READ_SCLK_MAX_KHZ = 9000; // Read clock ceiling
  localparam logic [2:0] HALF_LOAD = 3'(SCLK_HALF_CYC - 1);
  localparam logic [2:0] GAP_LOAD = 3'((SCLK_HALF_CYC > FRAME_GAP_CYC ? SCLK_HALF_CYC : FRAME_GAP_CYC) - 1);

endpackage

/* File: core/hvd_if.sv */
/*
  Serial link between the DAC control end and its master.
  Assumes the testbench instantiates it and joins both ends; sdo_wire is the
  resolved data output line.
*/
`timescale 1ns/1ps
interface hvd_if;
  logic sclk;          // Serial clock, made by the master
  logic frame_n;       // Frame select, active low
  logic sdi;           // Master to device data
  logic sdo;           // Device data output value
  logic sdo_oe;        // Device drives sdo while high
  logic load_n;        // Load output register, active low
  logic clear_n;       // Asynchronous clear, active low
  wire sdo_wire;       // Resolved line level

  // Released line shows the inverse, so a stray sample is caught
  assign sdo_wire = sdo_oe ? sdo : ~sdo;

  modport dev (input sclk, input frame_n, input sdi, input load_n, input clear_n,
               output sdo, output sdo_oe);
  modport host (output sclk, output frame_n, output sdi, output load_n,
                output clear_n, input sdo_wire);
endinterface

/* File: core/hvd_dev.sv */
/*
  Device end of the DAC control: serial slave, input, output and control
  registers, clear and load handling, latched thermal shutdown.
  Assumes every link pin and the over-temperature level are asynchronous to
  clock_in; the serial clock must stay well below a quarter of clock_in.
*/
`timescale 1ns/1ps
module hvd_dev (
  input wire logic clock_in,
  input wire logic rst_b_in,
  hvd_if.dev link,
  input wire logic over_temp_in,
  output logic [11:0] dac_code_out,
  output logic analog_on_out,
  output logic out_float_out,
  output logic out_ground_out,
  output logic alarm_n_out
);

  ////////////////////////////////////////////////////////////////////////////
  // Types and declarations

  // Frame sequencer states
  typedef enum logic [1:0] {
    HVD_IDLE = 2'b00,
    HVD_SHIFT = 2'b01,
    HVD_DONE = 2'b10
  } hvd_dev_st_t;

  hvd_dev_st_t st_q;                 // Frame state
  hvd_dev_st_t st_d;
  logic [5:0] meta_q;                // First synchroniser stage
  logic [5:0] sync_q;                // Second synchroniser stage
  logic [5:0] prev_q;                // Delayed copy for edges
  logic [4:0] cnt_q;                 // Rising edges seen in frame
  logic [15:0] shift_q;              // Incoming frame bits
  logic [11:0] input_q;              // Input register
  logic [11:0] dac_q;                // Output register
  logic power_up_q;                  // Channel power-up control
  logic float_sel_q;                 // Float versus ground when down
  logic thermal_q;                   // Latched shutdown flag
  logic [11:0] rd_sh_q;              // Readback shifter
  logic sdo_q;                       // Data output bit
  logic sdo_oe_q;                    // Data output enable
  logic [11:0] code_q;               // Registered outputs
  logic analog_on_q;
  logic float_q;
  logic ground_q;
  logic alarm_n_q;

  ////////////////////////////////////////////////////////////////////////////
  // Functions

  // Readback word for a select code; the output register has no path
  function automatic logic [11:0] readback(input logic [2:0] sel,
                                           input logic [11:0] inp,
                                           input logic [11:0] ctl);
    logic [11:0] w;
    w = 12'h000;
    if (sel == hvd_pkg::SEL_INPUT)
    begin
      w = inp;
    end
    else if (sel == hvd_pkg::SEL_CTRL)
    begin
      w = ctl;
    end
    return w;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Decoding

  // Synchronised views, index order matches SYNC_IDLE
  wire sclk_s = sync_q[5];
  wire sclk_p = prev_q[5];
  wire frame_high = sync_q[4];
  wire frame_fall = ~sync_q[4] & prev_q[4];
  wire sdi_s = sync_q[3];
  wire clear_fall = ~sync_q[2] & prev_q[2];
  wire load_fall = ~sync_q[1] & prev_q[1];
  wire load_low = ~sync_q[1];
  wire hot_s = sync_q[0];

  // Clock edges are only edges if the clock line actually moved
  wire sclk_rise = sclk_s & ~sclk_p;
  wire sclk_fall = ~sclk_s & sclk_p;
  wire in_frame = (st_q == HVD_SHIFT) & ~frame_high;

  // Field decode of the captured frame
  wire f_rw = shift_q[hvd_pkg::RW_POS];
  wire [2:0] f_sel = shift_q[hvd_pkg::SEL_MSB:hvd_pkg::SEL_LSB];
  wire [11:0] f_data = shift_q[11:0];
  wire ctrl_sel = (f_sel == hvd_pkg::SEL_CTRL);                           // (R17)

  // Command executes on the sixteenth falling edge only
  wire exec = in_frame & sclk_fall & (cnt_q == hvd_pkg::LAST_EDGE);       // (R11)
  wire wr_input = exec & ~f_rw & (f_sel == hvd_pkg::SEL_INPUT);           // (R9)
  wire wr_ctrl = exec & ~f_rw & ctrl_sel;                                 // (R9)

  // Shift in on rising edges until sixteen have arrived
  wire take_bit = in_frame & sclk_rise & (cnt_q < hvd_pkg::LAST_EDGE);    // (R10)

  // After four bits the read flag and select are known
  wire rd_start = in_frame & sclk_rise & (cnt_q == hvd_pkg::READ_DRIVE_CNT) & shift_q[3]; // (R15)
  wire rd_next = in_frame & sclk_rise & sdo_oe_q & (cnt_q < hvd_pkg::LAST_EDGE);

  // Control register image, reserved bits read zero
  wire [11:0] ctrl_word = {5'h00, float_sel_q, 3'h0, power_up_q, 1'b0, thermal_q}; // (R22)
  wire [11:0] rd_word = readback(shift_q[2:0], input_q, ctrl_word);       // (R7) (R14)

  // Thermal shutdown overrides the power-up bit
  wire analog_on = power_up_q & ~thermal_q;                               // (R4) (R20)

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers

  // Two stages before any logic, third stage for edge detection
  always_ff @(posedge clock_in)
  begin
    if (!rst_b_in)
    begin
      meta_q <= hvd_pkg::SYNC_IDLE;
      sync_q <= hvd_pkg::SYNC_IDLE;
      prev_q <= hvd_pkg::SYNC_IDLE;
    end
    else
    begin
      meta_q <= {link.sclk, link.frame_n, link.sdi, link.clear_n, link.load_n, over_temp_in};
      sync_q <= meta_q;
      prev_q <= sync_q;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Frame sequencer

  // Only a frame select fall opens a frame; held-low select waits in DONE
  always_comb
  begin
    st_d = st_q;
    case (st_q)
      HVD_IDLE:
      begin
        if (frame_fall)
        begin
          st_d = HVD_SHIFT;                                               // (R10)
        end
      end
      HVD_SHIFT:
      begin
        // Early select rise drops the partial frame
        if (frame_high)
        begin
          st_d = HVD_IDLE;                                                // (R24)
        end
        else if (exec)
        begin
          st_d = HVD_DONE;
        end
      end
      HVD_DONE:
      begin
        // Next frame needs select high first
        if (frame_high)
        begin
          st_d = HVD_IDLE;                                                // (R12)
        end
      end
      default:
      begin
        st_d = HVD_IDLE;
      end
    endcase
  end

  // State, bit count and shift register
  always_ff @(posedge clock_in)
  begin
    if (!rst_b_in)
    begin
      st_q <= HVD_IDLE;
      cnt_q <= 5'h00;
      shift_q <= 16'h0000;
    end
    else
    begin
      st_q <= st_d;
      if (frame_fall)
      begin
        cnt_q <= 5'h00;
      end
      else if (take_bit)
      begin
        cnt_q <= cnt_q + 5'h01;
        shift_q <= {shift_q[14:0], sdi_s};                                // (R8)
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Readback path

  // Drive from the fifth rising edge until frame select rises
  always_ff @(posedge clock_in)
  begin
    if (!rst_b_in)
    begin
      sdo_oe_q <= 1'b0;
      sdo_q <= 1'b0;
      rd_sh_q <= 12'h000;
    end
    else if (frame_high)
    begin
      sdo_oe_q <= 1'b0;                                                   // (R15)
    end
    else if (rd_start)
    begin
      sdo_oe_q <= 1'b1;                                                   // (R15)
      sdo_q <= rd_word[11];                                               // (R14)
      rd_sh_q <= {rd_word[10:0], 1'b0};
    end
    else if (rd_next)
    begin
      sdo_q <= rd_sh_q[11];                                               // (R14)
      rd_sh_q <= {rd_sh_q[10:0], 1'b0};
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Input and output registers

  // Clear wins over any load or write in the same cycle
  always_ff @(posedge clock_in)
  begin
    if (!rst_b_in)
    begin
      input_q <= hvd_pkg::DATA_RESET;                                     // (R19)
      dac_q <= hvd_pkg::DATA_RESET;                                       // (R19)
    end
    else if (clear_fall)
    begin
      input_q <= hvd_pkg::DATA_RESET;                                     // (R1)
      dac_q <= hvd_pkg::DATA_RESET;                                       // (R1)
    end
    else
    begin
      // Null and reserved selects fall through untouched
      if (wr_input)
      begin
        input_q <= f_data;                                                // (R23)
      end
      if (wr_input && load_low)
      begin
        dac_q <= f_data;                                                  // (R3)
      end
      else if (load_fall)
      begin
        dac_q <= input_q;                                                 // (R2)
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Control register and thermal latch

  // Set of the thermal flag wins over a clearing write
  always_ff @(posedge clock_in)
  begin
    if (!rst_b_in)
    begin
      power_up_q <= hvd_pkg::CTRL_RESET[hvd_pkg::POWER_UP_POS];           // (R19)
      float_sel_q <= hvd_pkg::CTRL_RESET[hvd_pkg::FLOAT_SEL_POS];         // (R19)
      thermal_q <= hvd_pkg::CTRL_RESET[hvd_pkg::THERMAL_FLAG_POS];
    end
    else
    begin
      if (wr_ctrl)
      begin
        power_up_q <= f_data[hvd_pkg::POWER_UP_POS];                      // (R20)
        float_sel_q <= f_data[hvd_pkg::FLOAT_SEL_POS];                    // (R21)
      end
      if (hot_s)
      begin
        thermal_q <= 1'b1;                                                // (R5)
      end
      else if (wr_ctrl && !f_data[hvd_pkg::THERMAL_FLAG_POS])
      begin
        thermal_q <= 1'b0;                                                // (R6)
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Analog control outputs

  // Registered so the analog side sees clean levels
  always_ff @(posedge clock_in)
  begin
    if (!rst_b_in)
    begin
      code_q <= hvd_pkg::DATA_RESET;
      analog_on_q <= 1'b0;
      float_q <= 1'b1;
      ground_q <= 1'b0;
      alarm_n_q <= 1'b1;
    end
    else
    begin
      code_q <= dac_q;
      analog_on_q <= analog_on;                                           // (R4)
      // Shutdown disconnects the output, so it floats
      float_q <= ~analog_on & (float_sel_q | thermal_q);                  // (R21)
      ground_q <= ~analog_on & ~float_sel_q & ~thermal_q;                 // (R21)
      alarm_n_q <= ~thermal_q;                                            // (R5)
    end
  end

  assign dac_code_out = code_q;
  assign analog_on_out = analog_on_q;
  assign out_float_out = float_q;
  assign out_ground_out = ground_q;
  assign alarm_n_out = alarm_n_q;
  assign link.sdo = sdo_q;
  assign link.sdo_oe = sdo_oe_q;

endmodule

/* File: core/hvd_host.sv */
/*
  Master end of the DAC control link: runs one 16-bit frame per request,
  makes the serial clock by dividing clock_in, collects readback data.
  Assumes the device end samples every pin with clock_in-rate logic.
*/
`timescale 1ns/1ps
module hvd_host (
  input wire logic clock_in,
  input wire logic rst_b_in,
  hvd_if.host link,
  input wire logic start_in,
  input wire logic rw_in,
  input wire logic [2:0] sel_in,
  input wire logic [11:0] data_in,
  input wire logic load_n_in,
  input wire logic clear_n_in,
  output logic busy_out,
  output logic done_out,
  output logic [11:0] rdata_out
);

  ////////////////////////////////////////////////////////////////////////////
  // Declarations

  // Frame phases
  typedef enum logic [2:0] {
    HVD_H_IDLE = 3'b000,
    HVD_H_LEAD = 3'b001,
    HVD_H_LOW = 3'b010,
    HVD_H_HIGH = 3'b011,
    HVD_H_TAIL = 3'b100,
    HVD_H_GAP = 3'b101
  } hvd_host_st_t;

  hvd_host_st_t st_q;            // Phase
  logic [2:0] tmr_q;             // Cycles left in phase
  logic [4:0] bit_q;             // Current bit, 1..16
  logic [15:0] frame_q;          // Outgoing bits
  logic [11:0] rd_q;             // Collected readback
  logic sclk_q;
  logic frame_n_q;
  logic sdi_q;
  logic load_n_q;
  logic clear_n_q;
  logic done_q;
  logic sdo_meta_q;              // Readback synchroniser
  logic sdo_s_q;

  // Phase end and last-sample point
  wire tick = (tmr_q == 3'h0);
  wire sample = tick & (((st_q == HVD_H_LOW) & (bit_q >= hvd_pkg::FIRST_SAMPLE_BIT)) |
                        (st_q == HVD_H_TAIL));                             // (R14)

  ////////////////////////////////////////////////////////////////////////////
  // Sequencer

  // Half period of 160 ns keeps reads far below the ceiling
  always_ff @(posedge clock_in)
  begin
    if (!rst_b_in)
    begin
      st_q <= HVD_H_IDLE;
      tmr_q <= 3'h0;
      bit_q <= 5'h00;
      frame_q <= 16'h0000;
      sclk_q <= 1'b0;
      frame_n_q <= 1'b1;
      sdi_q <= 1'b0;
      done_q <= 1'b0;
    end
    else
    begin
      done_q <= 1'b0;
      tmr_q <= tick ? tmr_q : tmr_q - 3'h1;
      case (st_q)
        HVD_H_IDLE:
        begin
          if (start_in)
          begin
            frame_q <= {rw_in, sel_in, data_in};                          // (R8) (R9)
            frame_n_q <= 1'b0;
            tmr_q <= hvd_pkg::HALF_LOAD;
            st_q <= HVD_H_LEAD;
          end
        end
        HVD_H_LEAD:
        begin
          if (tick)
          begin
            sdi_q <= frame_q[15];                                         // (R8)
            bit_q <= 5'h01;
            tmr_q <= hvd_pkg::HALF_LOAD;
            st_q <= HVD_H_LOW;
          end
        end
        HVD_H_LOW:
        begin
          if (tick)
          begin
            sclk_q <= 1'b1;                                               // (R16)
            tmr_q <= hvd_pkg::HALF_LOAD;
            st_q <= HVD_H_HIGH;
          end
        end
        HVD_H_HIGH:
        begin
          if (tick)
          begin
            sclk_q <= 1'b0;
            tmr_q <= hvd_pkg::HALF_LOAD;
            if (bit_q == hvd_pkg::LAST_EDGE)
            begin
              st_q <= HVD_H_TAIL;
            end
            else
            begin
              bit_q <= bit_q + 5'h01;
              frame_q <= {frame_q[14:0], 1'b0};
              sdi_q <= frame_q[14];
              st_q <= HVD_H_LOW;
            end
          end
        end
        HVD_H_TAIL:
        begin
          // Clock stops here until the next frame
          if (tick)
          begin
            frame_n_q <= 1'b1;                                            // (R13)
            done_q <= 1'b1;
            tmr_q <= hvd_pkg::GAP_LOAD;
            st_q <= HVD_H_GAP;
          end
        end
        HVD_H_GAP:
        begin
          if (tick)
          begin
            st_q <= HVD_H_IDLE;                                           // (R12)
          end
        end
        default:
        begin
          st_q <= HVD_H_IDLE;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Readback and side pins

  // Sample late in each low phase from bit 6 on and in the tail, after the device has settled
  always_ff @(posedge clock_in)
  begin
    if (!rst_b_in)
    begin
      sdo_meta_q <= 1'b0;
      sdo_s_q <= 1'b0;
      rd_q <= 12'h000;
      load_n_q <= 1'b1;
      clear_n_q <= 1'b1;
    end
    else
    begin
      sdo_meta_q <= link.sdo_wire;
      sdo_s_q <= sdo_meta_q;
      load_n_q <= load_n_in;
      clear_n_q <= clear_n_in;
      if (sample)
      begin
        rd_q <= {rd_q[10:0], sdo_s_q};                                    // (R14)
      end
    end
  end

  assign link.sclk = sclk_q;
  assign link.frame_n = frame_n_q;
  assign link.sdi = sdi_q;
  assign link.load_n = load_n_q;
  assign link.clear_n = clear_n_q;
  assign busy_out = (st_q != HVD_H_IDLE);
  assign done_out = done_q;
  assign rdata_out = rd_q;

endmodule

/* File: dv/hvd_link_monitor.sv */
/*
  Checker on the serial link between host and device ends.
  Assumes clock_in samples every link signal; the host runs the frames.
*/
`timescale 1ns/1ps
module hvd_link_monitor (
  input wire logic clock_in,
  input wire logic rst_b_in,
  input wire logic sclk,
  input wire logic frame_n,
  input wire logic sdi,
  input wire logic sdo_oe
);
  ////////////////////////////////////////////////////////////////////////////
  logic sclk_q; // Last sampled serial clock
  logic rw_q; // First bit of the frame
  logic [4:0] rise_q; // Clock rises seen in this frame
  wire rise = sclk && !sclk_q;

  // Count rises per frame; cleared while select is high
  always_ff @(posedge clock_in)
  begin
    sclk_q <= sclk;
    if (!rst_b_in || frame_n)
      rise_q <= 5'h00;
    else if (rise)
      rise_q <= rise_q + 5'h01;
    if (rise && rise_q == 5'h00)
      rw_q <= sdi;
  end

  ////////////////////////////////////////////////////////////////////////////
  default clocking @(posedge clock_in); endclocking
  default disable iff (!rst_b_in);

  property p_oe_idle; frame_n [*4] |-> !sdo_oe; endproperty
  a_oe_idle: assert property (p_oe_idle) else $error("sdo driven between frames");
  property p_oe_fifth; $rose(sdo_oe) |-> rise_q == 5'h05 && rw_q; endproperty
  a_oe_fifth: assert property (p_oe_fifth) else $error("sdo driven at wrong edge");
  property p_gap; $rose(frame_n) |=> frame_n [*3]; endproperty
  a_gap: assert property (p_gap) else $error("frame gap too short");
  property p_len; $rose(frame_n) |-> rise_q == 5'h10; endproperty
  a_len: assert property (p_len) else $error("frame not sixteen clocks");
  property p_idle_clk; frame_n |-> !sclk; endproperty
  a_idle_clk: assert property (p_idle_clk) else $error("clock runs outside frame");
  property p_high; $rose(sclk) |-> sclk [*4] ##1 !sclk; endproperty
  a_high: assert property (p_high) else $error("clock high phase wrong");
  property p_sdi; sclk |-> $stable(sdi); endproperty
  a_sdi: assert property (p_sdi) else $error("sdi moved while clock high");
  property p_span; $fell(frame_n) |-> ##[128:136] $rose(frame_n); endproperty
  a_span: assert property (p_span) else $error("frame length wrong");
endmodule

/* File: dv/hv_dac_serial_control_test.sv */
/*
  Testbench: host and device ends joined by the link interface.
  Assumes a 25 MHz clock; an integer model predicts every result.
*/
`timescale 1ns/1ps
module hv_dac_serial_control_test;
  logic clock_in = 1'b0;
  logic rst_b_in, start_in, rw_in, load_n_in, clear_n_in, over_temp_in;
  logic [2:0] sel_in;
  logic [11:0] data_in, dac_code_out, rdata_out;
  logic busy_out, done_out, analog_on_out, out_float_out, out_ground_out, alarm_n_out;
  int error_cnt = 0;
  int compares = 0;
  int inp, outp, pu, fl, th, lo, clr, hot, s; // Model state
  hvd_if link_if ();
  hvd_dev hvd_dev_inst (.clock_in(clock_in), .rst_b_in(rst_b_in), .link(link_if),
    .over_temp_in(over_temp_in), .dac_code_out(dac_code_out), .analog_on_out(analog_on_out),
    .out_float_out(out_float_out), .out_ground_out(out_ground_out), .alarm_n_out(alarm_n_out));
  hvd_host hvd_host_inst (.clock_in(clock_in), .rst_b_in(rst_b_in), .link(link_if),
    .start_in(start_in), .rw_in(rw_in), .sel_in(sel_in), .data_in(data_in), .load_n_in(load_n_in),
    .clear_n_in(clear_n_in), .busy_out(busy_out), .done_out(done_out), .rdata_out(rdata_out));
  hvd_link_monitor hvd_link_monitor_inst (.clock_in(clock_in), .rst_b_in(rst_b_in),
    .sclk(link_if.sclk), .frame_n(link_if.frame_n), .sdi(link_if.sdi), .sdo_oe(link_if.sdo_oe));
  always #20 clock_in = ~clock_in;

  ////////////////////////////////////////////////////////////////////////////
  // One compare; unknowns never match
  task automatic chk(input string what, input logic [11:0] e, input logic [11:0] g);
    compares++;
    if (g !== e)
    begin
      error_cnt++;
      $display("mismatch %s expected %h seen %h", what, e, g);
    end
  endtask

  task automatic final_report;
    $display("compares %0d mismatches %0d", compares, error_cnt);
    if (error_cnt == 0 && compares > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  // Device outputs against the model
  task automatic chk_out;
    logic on;
    repeat (10) @(posedge clock_in);
    on = pu != 0 && th == 0;
    chk("dac code", 12'(outp), dac_code_out);
    chk("alarm", 12'(th == 0), 12'(alarm_n_out));
    chk("analog on", 12'(on), 12'(analog_on_out));
    chk("float", 12'(!on && (fl || th)), 12'(out_float_out));
    chk("ground", 12'(!on && !fl && !th), 12'(out_ground_out));
    chk("busy idle", 12'h000, 12'(busy_out));
  endtask

  // Pin change; clear applied after load so it wins
  task automatic pins(input logic ld, input logic cl, input logic ho);
    @(posedge clock_in);
    load_n_in <= ld;
    clear_n_in <= cl;
    over_temp_in <= ho;
    if (lo && !ld) outp = inp;
    if (clr && !cl)
    begin
      inp = 0;
      outp = 0;
    end
    if (ho) th = 1;
    lo = ld;
    clr = cl;
    hot = ho;
    chk_out;
  endtask

  // One frame through the host; model updated after
  task automatic xfer(input logic rw, input logic [2:0] sel, input logic [11:0] d);
    int n;
    int e;
    e = sel == 3'h1 ? inp : sel == 3'h7 ? (fl << 6 | pu << 2 | th) : 0;
    @(posedge clock_in);
    start_in <= 1'b1;
    rw_in <= rw;
    sel_in <= sel;
    data_in <= d;
    @(posedge clock_in);
    start_in <= 1'b0;
    n = 0;
    while (done_out !== 1'b1 && n < 400)
    begin
      @(posedge clock_in);
      #1;
      n++;
    end
    chk("frame done", 12'h001, 12'(done_out));
    chk("busy in gap", 12'h001, 12'(busy_out));
    if (rw) chk("readback", 12'(e), rdata_out);
    else if (sel == 3'h1)
    begin
      inp = d;
      if (lo == 0) outp = d;
    end
    else if (sel == 3'h7)
    begin
      pu = d[2];
      fl = d[6];
      if (!d[0] && !hot) th = 0;
    end
    chk_out;
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // Hang guard
  initial
  begin
    repeat (30000) @(posedge clock_in);
    error_cnt++;
    final_report;
  end

  // Main sequence
  initial
  begin
    rst_b_in <= 1'b0;
    start_in <= 1'b0;
    rw_in <= 1'b0;
    sel_in <= 3'h0;
    data_in <= 12'h000;
    load_n_in <= 1'b1;
    clear_n_in <= 1'b1;
    over_temp_in <= 1'b0;
    inp = 0;
    outp = 0;
    pu = 0;
    fl = 1;
    th = 0;
    lo = 1;
    clr = 1;
    hot = 0;
    void'($urandom(32'h69f2_0d1a));
    repeat (10) @(posedge clock_in);
    rst_b_in <= 1'b1;
    chk_out;
    xfer(1, 3'h7, 12'h000);
    xfer(1, 3'h1, 12'h000);
    $display("test reset done");
    repeat (3)
    begin
      xfer(0, 3'h1, 12'($urandom));
      xfer(1, 3'h1, 12'h000);
    end
    pins(0, 1, 0);
    pins(1, 1, 0);
    $display("test load done");
    pins(0, 1, 0);
    xfer(0, 3'h1, 12'hfff);
    xfer(0, 3'h1, 12'($urandom));
    pins(1, 1, 0);
    $display("test auto update done");
    for (s = 0; s < 7; s++)
      if (s != 1)
      begin
        xfer(0, 3'(s), 12'($urandom));
        xfer(1, 3'(s), 12'h000);
      end
    $display("test nop codes done");
    for (s = 0; s < 4; s++)
    begin
      xfer(0, 3'h7, 12'(s[0]) << 2 | 12'(s[1]) << 6);
      xfer(0, 3'h0, 12'h000);
      xfer(1, 3'h7, 12'h000);
    end
    $display("test control done");
    xfer(0, 3'h1, 12'h5a5);
    pins(0, 1, 0);
    pins(0, 0, 0);
    xfer(1, 3'h1, 12'h000);
    pins(1, 1, 0);
    $display("test clear done");
    xfer(0, 3'h7, 12'h004);
    pins(1, 1, 1);
    xfer(1, 3'h7, 12'h000);
    pins(1, 1, 0);
    xfer(0, 3'h1, 12'($urandom));
    xfer(0, 3'h7, 12'h004);
    xfer(1, 3'h7, 12'h000);
    $display("test thermal done");
    final_report;
  end
endmodule
